// *** src/ddg_top.sv ***
// Device disable and GPIO configuration registers behind an Avalon-MM slave.
//
// Behaviour
// [RL1] Disable bits override activate bits when set.
// [RL2] Register read-only when lock field 01, pin high.
// [RL3] Write-protect bit forces protection on.
// [RL4] Protect output is OR of four sources.
// [RL5] Bits two and one read zero.
// [RL6] Bit three disables the floppy controller.
// [RL7] Bit five disables the MIDI UART.
// [RL8] Bit six disables the serial UART.
// [RL9] Bit seven disables the parallel port.
// [RL10] GPIO bit zero: one input, zero output.
// [RL11] GPIO bit one inverts pin sense.
// [RL12] GPIO bit two routes pin to joystick.
// [RL13] GPIO bit seven selects open-drain drive.
// [RL14] Polarity applies to input and output.
// [RL15] Locked writes leave all bits unchanged.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module ddg_top (
   input  wire logic                 ref_clk,
   input  wire logic                 nrst,
   input  wire ddg_pkg::ddg_avs_req_t avs_req,
   output var  logic [31:0]          avs_readdata,
   output var  logic                 avs_waitrequest,
   input  wire logic [1:0]           lock_cfg,
   input  wire logic                 lock_control_pin,
   input  wire logic                 floppy_activate,
   input  wire logic                 midi_activate,
   input  wire logic                 uart_activate,
   input  wire logic                 parallel_port_activate,
   output var  logic                 floppy_enable,
   output var  logic                 midi_enable,
   output var  logic                 uart_enable,
   output var  logic                 parallel_port_enable,
   input  wire logic                 write_protect_n,
   input  wire logic                 drive_select0_n,
   input  wire logic                 drive_select1_n,
   input  wire logic                 force_write_protect,
   output var  logic                 write_protect_core_n,
   output var  logic                 floppy_status_a_wp,
   input  wire logic                 gpio_drive_val,
   output var  logic                 gpio_read_val,
   output var  logic                 joystick1_button1,
   input  wire logic                 gpio_pin_i,
   output var  logic                 gpio_pin_o,
   output var  logic                 gpio_pin_oe
);

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode.

   logic                      req_take;
   logic                      addr_word;
   logic [7:0]                addr_idx;
   logic                      hit_dd;
   logic                      hit_gc;
   logic                      locked;
   logic                      we_dd;
   logic                      we_gc;
   logic [7:0]                dd_raw;
   logic [7:0]                gc_raw;
   ddg_pkg::ddg_dev_disable_t dd_q;
   ddg_pkg::ddg_gpio_cfg_t    gc_q;
   logic [7:0]                rd_d;

   // A request is taken only in the cycle when waitrequest is still high, so a
   // request held across the answer edge is not taken twice.
   assign req_take  = (avs_req.read || avs_req.write) && avs_waitrequest;
   assign addr_word = (avs_req.address[1:0] == 2'h0);
   assign addr_idx  = avs_req.address[9:2];
   assign hit_dd    = addr_word && (addr_idx == ddg_pkg::IDX_DEV_DISABLE);
   assign hit_gc    = addr_word && (addr_idx == ddg_pkg::IDX_GPIO_CFG);

   // [RL2] lock condition decode
   assign locked = (lock_cfg == ddg_pkg::LOCK_FIELD_ARMED) && lock_control_pin;

   // [RL15] locked write dropped
   assign we_dd = req_take && avs_req.write && avs_req.byteenable[0] && hit_dd && !locked;
   assign we_gc = req_take && avs_req.write && avs_req.byteenable[0] && hit_gc;

   ////////////////////////////////////////////////////////////////////////////////
   // Registers.

   // [RL5] reserved bits held zero
   ddg_reg8 #(
      .RESET_VAL (ddg_pkg::RST_DEV_DISABLE),
      .WMASK     (ddg_pkg::MASK_DEV_DISABLE)
   ) u_dev_disable (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .we      (we_dd),
      .wdata   (avs_req.writedata[7:0]),
      .q       (dd_raw)
   );

   // [RL13] reserved GPIO bits
   ddg_reg8 #(
      .RESET_VAL (ddg_pkg::RST_GPIO_CFG),
      .WMASK     (ddg_pkg::MASK_GPIO_CFG)
   ) u_gpio_cfg (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .we      (we_gc),
      .wdata   (avs_req.writedata[7:0]),
      .q       (gc_raw)
   );

   assign dd_q = ddg_pkg::ddg_dev_disable_t'(dd_raw);
   assign gc_q = ddg_pkg::ddg_gpio_cfg_t'(gc_raw);

   ////////////////////////////////////////////////////////////////////////////////
   // Read path and waitrequest.

   always_comb
   begin
      rd_d = 8'h00;
      if (hit_dd)
      begin
         rd_d = dd_raw;
      end
      else if (hit_gc)
      begin
         rd_d = gc_raw;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end
      else if (req_take)
      begin
         // Unmapped addresses answer with zero and ignore writes.
         avs_waitrequest <= 1'b0;
         avs_readdata    <= avs_req.read ? {24'h00_0000, rd_d} : 32'h0000_0000;
      end
      else
      begin
         avs_waitrequest <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Logical device enables.

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         floppy_enable        <= 1'b0;
         midi_enable          <= 1'b0;
         uart_enable          <= 1'b0;
         parallel_port_enable <= 1'b0;
      end
      else
      begin
         // [RL1] [RL6] floppy override
         floppy_enable        <= floppy_activate && !dd_q.fdc;
         // [RL7] MIDI override
         midi_enable          <= midi_activate && !dd_q.midi;
         // [RL8] serial override
         uart_enable          <= uart_activate && !dd_q.uart;
         // [RL9] parallel override
         parallel_port_enable <= parallel_port_activate && !dd_q.pp;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Floppy write protect.

   logic wp_d;

   // [RL3] [RL4] protect OR sources
   assign wp_d = dd_q.wp || write_protect_n
                 || (drive_select0_n && force_write_protect)
                 || (drive_select1_n && force_write_protect);

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         write_protect_core_n <= 1'b0;
         floppy_status_a_wp   <= 1'b0;
      end
      else
      begin
         write_protect_core_n <= wp_d;
         floppy_status_a_wp   <= wp_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // GPIO pin.

   ddg_gpio_cell u_gpio (
      .ref_clk   (ref_clk),
      .nrst      (nrst),
      .cfg       (gc_q),
      .drive_val (gpio_drive_val),
      .pin_i     (gpio_pin_i),
      .pin_o     (gpio_pin_o),
      .pin_oe    (gpio_pin_oe),
      .read_val  (gpio_read_val),
      .joy_btn   (joystick1_button1)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   // The sampled reset term stops the attempt at the release edge from comparing
   // inputs of that edge against flops that were still held in reset.
   // [RL1] [RL6] enable follows activate
   a_fdc_enable_follow: assert property (
      nrst && !dd_q.fdc |=> floppy_enable == $past(floppy_activate))
      else $error("floppy enable does not follow activate");

   // [RL6] floppy disabled
   a_fdc_disabled: assert property (dd_q.fdc |=> !floppy_enable)
      else $error("floppy enabled while disabled");

   // [RL7] MIDI disabled
   a_midi_disabled: assert property (
      dd_q.midi |=> !midi_enable)
      else $error("MIDI enabled while disabled");

   // [RL8] serial follows activate
   a_uart_enable_rule: assert property (
      nrst ##1 uart_enable == ($past(uart_activate) && !$past(dd_q.uart)))
      else $error("serial enable wrong");

   // [RL9] parallel disabled
   a_pp_disabled: assert property (
      dd_q.pp && parallel_port_activate |=> !parallel_port_enable)
      else $error("parallel port enabled while disabled");

   // [RL2] [RL15] locked write ignored
   a_locked_write_hold: assert property (
      req_take && avs_req.write && hit_dd && locked |=> $stable(dd_raw))
      else $error("locked disable register changed");

   // [RL2] unlocked write stored
   a_unlocked_write: assert property (
      we_dd |=> dd_raw == ($past(avs_req.writedata[7:0]) & ddg_pkg::MASK_DEV_DISABLE))
      else $error("disable register write lost");

   // [RL5] reserved bits read zero
   a_rsvd_read_zero: assert property (
      req_take && avs_req.read && hit_dd |=> avs_readdata[2:1] == 2'h0 && !avs_waitrequest)
      else $error("reserved disable bits read nonzero");

   // [RL3] override forces protect
   a_wp_override: assert property (
      dd_q.wp |=> write_protect_core_n && floppy_status_a_wp)
      else $error("write protect override ignored");

   // [RL4] protect equation
   a_wp_equation: assert property (
      nrst ##1 write_protect_core_n == $past(wp_d) && floppy_status_a_wp == write_protect_core_n)
      else $error("write protect output mismatch");

   // [RL10] input releases pin
   a_gpio_dir_in: assert property (
      gc_q.dir_in |=> !gpio_pin_oe)
      else $error("pin driven while input");

   // [RL11] output polarity push-pull
   a_gpio_out_pol: assert property (
      !gc_q.dir_in && !gc_q.alt_joy && !gc_q.open_drain
      |=> gpio_pin_oe && gpio_pin_o == ($past(gpio_drive_val) ^ $past(gc_q.invert)))
      else $error("pushed pin level wrong");

   // [RL13] open drain never drives high
   a_gpio_open_drain: assert property (
      gc_q.open_drain |=> !(gpio_pin_oe && gpio_pin_o))
      else $error("open-drain pin drove high");

   // [RL12] joystick routing
   a_gpio_joystick: assert property (
      gc_q.alt_joy |=> joystick1_button1 == $past(gpio_pin_i) && !gpio_pin_oe)
      else $error("joystick button not routed");

   // [RL14] input polarity
   a_gpio_in_pol: assert property (
      nrst && !gc_q.alt_joy |=> gpio_read_val == ($past(gpio_pin_i) ^ $past(gc_q.invert)))
      else $error("input polarity wrong");

   // Waitrequest low lasts exactly one cycle per request.
   a_wait_one_cycle: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");

endmodule

`default_nettype wire

// *** src/ddg_pkg.sv ***
// Shared constants and carrier types for the device disable and GPIO configuration block.
package ddg_pkg;

   // Byte address width of the register slave.
   localparam int          AVS_ADDR_W       = 10;

   // Register indices; the byte address is four times the index.
   localparam logic [7:0]  IDX_DEV_DISABLE  = 8'h22;
   localparam logic [7:0]  IDX_GPIO_CFG     = 8'h23;

   // Reset values, applied on standby power-on reset.
   localparam logic [7:0]  RST_DEV_DISABLE  = 8'h00;
   localparam logic [7:0]  RST_GPIO_CFG     = 8'h01;

   // Storable bits; reserved positions hold zero and read as zero.
   localparam logic [7:0]  MASK_DEV_DISABLE = 8'hE9;
   localparam logic [7:0]  MASK_GPIO_CFG    = 8'h87;

   // Lock pin configuration field value that arms the lock.
   localparam logic [1:0]  LOCK_FIELD_ARMED = 2'h1;

   typedef struct packed {
      logic       pp;
      logic       uart;
      logic       midi;
      logic       rsvd4;
      logic       fdc;
      logic [1:0] rsvd21;
      logic       wp;
   } ddg_dev_disable_t;

   typedef struct packed {
      logic       open_drain;
      logic [3:0] rsvd;
      logic       alt_joy;
      logic       invert;
      logic       dir_in;
   } ddg_gpio_cfg_t;

   typedef struct packed {
      logic                  read;
      logic                  write;
      logic [AVS_ADDR_W-1:0] address;
      logic [31:0]           writedata;
      logic [3:0]            byteenable;
   } ddg_avs_req_t;

endpackage

// *** src/ddg_reg8.sv ***
// Eight-bit software register whose reserved bits are held at zero.
`timescale 1ns/1ps
`default_nettype none

module ddg_reg8 #(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] WMASK     = 8'hFF
) (
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       we,
   input  wire logic [7:0] wdata,
   output var  logic [7:0] q
);

   // A register with no storable bit, or a reset value in reserved bits, cannot serve.
   if ((WMASK == 8'h00) || ((RESET_VAL & ~WMASK) != 8'h00))
   begin : g_bad_param
      $error("ddg_reg8: mask or reset value unusable");
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         q <= RESET_VAL;
      end
      else if (we)
      begin
         q <= wdata & WMASK;
      end
   end

endmodule

`default_nettype wire

// *** src/ddg_gpio_cell.sv ***
// One general-purpose pin with direction, polarity, alternate joystick input and driver type.
`timescale 1ns/1ps
`default_nettype none

module ddg_gpio_cell (
   input  wire logic               ref_clk,
   input  wire logic               nrst,
   input  wire ddg_pkg::ddg_gpio_cfg_t cfg,
   input  wire logic               drive_val,
   input  wire logic               pin_i,
   output var  logic               pin_o,
   output var  logic               pin_oe,
   output var  logic               read_val,
   output var  logic               joy_btn
);

   logic out_lvl;

   // [RL14] polarity on output
   assign out_lvl = drive_val ^ cfg.invert;

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_o  <= 1'b0;
         pin_oe <= 1'b0;
      end
      // [RL12] joystick releases pin
      else if (cfg.alt_joy || cfg.dir_in)
      begin
         // [RL10] input means undriven
         pin_o  <= 1'b0;
         pin_oe <= 1'b0;
      end
      // [RL13] open-drain driver type
      else if (cfg.open_drain)
      begin
         pin_o  <= 1'b0;
         pin_oe <= ~out_lvl;
      end
      else
      begin
         pin_o  <= out_lvl;
         pin_oe <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         read_val <= 1'b0;
         joy_btn  <= 1'b0;
      end
      else
      begin
         // [RL11] [RL14] polarity on input
         read_val <= cfg.alt_joy ? 1'b0 : (pin_i ^ cfg.invert);
         // [RL12] joystick button routing
         joy_btn  <= cfg.alt_joy ? pin_i : 1'b0;
      end
   end

endmodule

`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking random bench for the device disable and GPIO configuration block.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic                  ref_clk = 1'b0;
   logic                  nrst = 1'b0;
   ddg_pkg::ddg_avs_req_t req = '0;
   logic [31:0]           rdata;
   logic                  waitreq;
   logic [1:0]            lock_cfg = 2'h0;
   logic                  lock_pin = 1'b0;
   logic [3:0]            act = 4'h0;
   logic [3:0]            en;
   logic [3:0]            wpi = 4'h0;
   logic                  wp_core_n;
   logic                  wp_sra;
   logic                  drv = 1'b0;
   logic                  ext = 1'b0;
   logic                  rd_val;
   logic                  joy;
   logic                  pin_o;
   logic                  pin_oe;
   wire logic             pin_w;
   logic [7:0]            dis_m;
   logic [7:0]            gp_m;
   logic [7:0]            r;
   int                    miscompares = 0;
   int                    n_tests = 0;
   int                    cycles = 0;

   // The pin wire follows the block while it drives, else the outside party.
   assign pin_w = pin_oe ? pin_o : ext;

   ddg_top uut (
      .ref_clk                (ref_clk),
      .nrst                   (nrst),
      .avs_req                (req),
      .avs_readdata           (rdata),
      .avs_waitrequest        (waitreq),
      .lock_cfg               (lock_cfg),
      .lock_control_pin       (lock_pin),
      .floppy_activate        (act[3]),
      .midi_activate          (act[2]),
      .uart_activate          (act[1]),
      .parallel_port_activate (act[0]),
      .floppy_enable          (en[3]),
      .midi_enable            (en[2]),
      .uart_enable            (en[1]),
      .parallel_port_enable   (en[0]),
      .write_protect_n        (wpi[3]),
      .drive_select0_n        (wpi[2]),
      .drive_select1_n        (wpi[1]),
      .force_write_protect    (wpi[0]),
      .write_protect_core_n   (wp_core_n),
      .floppy_status_a_wp     (wp_sra),
      .gpio_drive_val         (drv),
      .gpio_read_val          (rd_val),
      .joystick1_button1      (joy),
      .gpio_pin_i             (pin_w),
      .gpio_pin_o             (pin_o),
      .gpio_pin_oe            (pin_oe)
   );

   always #12.5 ref_clk = ~ref_clk;

   task automatic end_sim();
      if (miscompares == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // A hung handshake would otherwise stall the run forever.
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         miscompares++;
         end_sim();
      end
   end

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One bus transfer; the answer is expected exactly two edges after raising.
   task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
                      input logic [3:0] be, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge ref_clk);
      req.write <= wr;
      req.read <= ~wr;
      req.address <= a;
      req.writedata <= {24'hA5A5A5, d};
      req.byteenable <= be;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (waitreq !== 1'b0);
      q = rdata[7:0];
      req.write <= 1'b0;
      req.read <= 1'b0;
      cmp1(n == 2, 1'b1);
      if (!wr)
         cmp8(rdata[31:24], 8'h00);
   endtask

   // Expected protect level: override bit or any of the three pin terms.
   function automatic logic exp_wp(input logic [7:0] dis, input logic [3:0] w);
      return dis[0] | w[3] | (w[2] & w[0]) | (w[1] & w[0]);
   endfunction

   // Expected output enable: off in input or joystick mode; otherwise push-pull drives, open-drain only pulls low.
   function automatic logic exp_oe(input logic [7:0] g, input logic v);
      return ~g[2] & ~g[0] & (g[7] ? ~v : 1'b1);
   endfunction

   task automatic do_reset();
      nrst <= 1'b0;
      repeat (16) @(posedge ref_clk);
      nrst <= 1'b1;
      dis_m = 8'h00;
      gp_m = 8'h01;
   endtask

   task automatic check_defaults();
      bus(1'b0, 10'h088, 8'h00, 4'hF, r);
      cmp8(r, 8'h00);
      bus(1'b0, 10'h08C, 8'h00, 4'hF, r);
      cmp8(r, 8'h01);
   endtask

   // Outputs are registered, so two quiet edges let every level settle.
   task automatic check_out();
      logic inv;
      logic v;
      logic oe_e;
      logic o_e;
      logic pin;
      logic wp_e;
      @(posedge ref_clk);
      @(posedge ref_clk);
      #1;
      cmp1(en[3], act[3] & ~dis_m[3]);
      cmp1(en[2], act[2] & ~dis_m[5]);
      cmp1(en[1], act[1] & ~dis_m[6]);
      cmp1(en[0], act[0] & ~dis_m[7]);
      wp_e = exp_wp(dis_m, wpi);
      cmp1(wp_core_n, wp_e);
      cmp1(wp_sra, wp_e);
      inv = gp_m[1];
      v = drv ^ inv;
      oe_e = exp_oe(gp_m, v);
      o_e = ~gp_m[7] & v;
      pin = oe_e ? o_e : ext;
      cmp1(pin_oe, oe_e);
      cmp1(pin_o, oe_e & o_e);
      cmp1(rd_val, ~gp_m[2] & (pin ^ inv));
      cmp1(joy, gp_m[2] & pin);
   endtask

   initial
   begin
      logic [7:0] d;
      logic [7:0] g;
      logic [3:0] be;
      void'($urandom(1075));
      do_reset();
      check_defaults();
      bus(1'b1, 10'h090, 8'hFF, 4'hF, r);
      bus(1'b0, 10'h090, 8'h00, 4'hF, r);
      cmp8(r, 8'h00);
      bus(1'b0, 10'h089, 8'h00, 4'hF, r);
      cmp8(r, 8'h00);
      for (int i = 0; i < 80; i++)
      begin
         @(posedge ref_clk);
         lock_cfg <= (i < 8) ? 2'h1 : 2'($urandom);
         lock_pin <= (i < 8) ? i[0] : 1'($urandom);
         act <= 4'($urandom);
         wpi <= 4'($urandom);
         drv <= 1'($urandom);
         ext <= 1'($urandom);
         d = (i < 8) ? 8'hFF ^ 8'(i) : 8'($urandom);
         g = 8'($urandom);
         be = (i < 8) ? 4'h1 : 4'($urandom);
         bus(1'b1, 10'h088, d, be, r);
         if (be[0] && !(lock_cfg == 2'h1 && lock_pin))
            dis_m = d & 8'hE9;
         bus(1'b1, 10'h08C, g, be, r);
         if (be[0])
            gp_m = g & 8'h87;
         bus(1'b0, 10'h088, 8'h00, 4'hF, r);
         cmp8(r, dis_m);
         bus(1'b0, 10'h08C, 8'h00, 4'hF, r);
         cmp8(r, gp_m);
         check_out();
      end
      do_reset();
      check_defaults();
      check_out();
      end_sim();
   end
endmodule

`default_nettype wire
